/* File: lfb_addr_gen.sv */
// Frame-buffer address generator: registers, burst DMA fetch and line/frame sequencing.
// Assumes a word-wide memory read port with four data beats per grant, and a display
// FIFO that raises fifoReady only while it has room for a whole burst.
`timescale 1ns/100ps
`include "lfb_cfg.svh"
module lfb_addr_gen (
  // Clock, reset, clock enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port.
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  // Memory burst read port.
  output logic memReq,
  output logic [27:0] memAddr,
  input wire logic memGnt,
  input wire logic memRdValid,
  input wire logic [31:0] memRdData,
  // Display FIFO side.
  input wire logic fifoReady,
  output logic fifoWrValid,
  output logic [31:0] fifoWrData,
  output logic fifoFlush,
  output logic fifoLowerHalf,
  // Panel settings and status.
  output logic displayEnable,
  output logic panelSelfRefreshEn,
  output lfb_pkg::lfb_pix_t pixelFormatSel,
  output lfb_pkg::lfb_scan_t scanMode,
  output logic altDriveSignal,
  output logic frameEnd
);
  import lfb_pkg::*;

  logic [31:0] control_ff;
  logic [31:0] size_ff;
  logic [31:0] frameStartUpper_ff;
  logic [31:0] frameStartLower_ff;
  logic [31:0] geometry_ff;
  logic [31:0] testControl_ff;
  logic [31:0] rdData_ff;
  lfb_state_t state_ff;
  logic [1:0] beat_ff;
  logic [5:0] bankAct_ff;
  logic [20:0] curPtr_ff;
  logic [20:0] startU_ff;
  logic [20:0] startL_ff;
  logic onLower_ff;
  logic [9:0] rem_ff;
  logic [9:0] line_counter_ff;
  logic fifoWrValid_ff;
  logic [31:0] fifoWrData_ff;
  logic [31:0] swapped;
  logic [8:0] page_width_a;
  logic [10:0] lineOffset;
  logic [9:0] vertLines;
  logic dualScan;
  logic lastBurst;
  logic lineDone;
  logic frameDone;
  logic beatTaken;
  logic [20:0] newStart;

  assign displayEnable = control_ff[`LFB_ENABLE_BIT];
  assign page_width_a = geometry_ff[`LFB_PW_HI:`LFB_PW_LO];
  assign lineOffset = geometry_ff[`LFB_OFF_HI:`LFB_OFF_LO];
  assign vertLines = size_ff[`LFB_VLC_HI:`LFB_VLC_LO];
  assign dualScan = (scanMode == SCAN_DUAL4);
  assign panelSelfRefreshEn = testControl_ff[`LFB_SREF_BIT];
  assign pixelFormatSel = lfb_pix_t'(frameStartUpper_ff[`LFB_PIX_HI:`LFB_PIX_LO]);
  assign scanMode = lfb_scan_t'(control_ff[`LFB_SCAN_HI:`LFB_SCAN_LO]);
  assign regRdData = rdData_ff;

  // Register writes; the line counter field is read-only.
  always_ff @(posedge clk) begin
    if (rst) begin
      control_ff <= `LFB_RST_REG;
      size_ff <= `LFB_RST_REG;
      frameStartUpper_ff <= `LFB_RST_REG;
      frameStartLower_ff <= `LFB_RST_REG;
      geometry_ff <= `LFB_RST_REG;
      testControl_ff <= `LFB_RST_REG;
    end else if (ce && regWrStb) begin
      if (regAddr == `LFB_OFS_CONTROL) begin
        control_ff <= regWrData & `LFB_MASK_CONTROL;
      end else if (regAddr == `LFB_OFS_SIZE) begin
        size_ff <= regWrData & `LFB_MASK_SIZE;
      end else if (regAddr == `LFB_OFS_UPPER) begin
        frameStartUpper_ff <= regWrData & `LFB_MASK_UPPER;
      end else if (regAddr == `LFB_OFS_LOWER) begin
        frameStartLower_ff <= regWrData & `LFB_MASK_LOWER;
      end else if (regAddr == `LFB_OFS_GEOM) begin
        geometry_ff <= regWrData & `LFB_MASK_GEOM;
      end else if (regAddr == `LFB_OFS_TEST) begin
        testControl_ff <= regWrData & `LFB_MASK_TEST;
      end
    end
  end

  // Read data stands in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_ff <= `LFB_RST_REG;
    end else if (ce && regRdStb) begin
      if (regAddr == `LFB_OFS_CONTROL) begin
        rdData_ff <= {line_counter_ff, control_ff[21:0]};
      end else if (regAddr == `LFB_OFS_SIZE) begin
        rdData_ff <= size_ff;
      end else if (regAddr == `LFB_OFS_UPPER) begin
        rdData_ff <= frameStartUpper_ff;
      end else if (regAddr == `LFB_OFS_LOWER) begin
        rdData_ff <= frameStartLower_ff;
      end else if (regAddr == `LFB_OFS_GEOM) begin
        rdData_ff <= geometry_ff;
      end else if (regAddr == `LFB_OFS_TEST) begin
        rdData_ff <= testControl_ff;
      end else begin
        rdData_ff <= `LFB_RST_REG;
      end
    end
  end

  // Burst and line bookkeeping.
  assign lastBurst = (rem_ff <= `LFB_BURST_HW);
  assign lineDone = ce && displayEnable && (state_ff == ST_STEP) && lastBurst;
  assign frameDone = lineDone && (!dualScan || onLower_ff) && (line_counter_ff == 10'h000);
  assign frameEnd = frameDone;
  assign beatTaken = (state_ff == ST_BEAT) && memRdValid;
  assign newStart = (onLower_ff ? startL_ff : startU_ff) + {12'h000, page_width_a}
    + {10'h000, lineOffset};

  // Request stands while waiting for a grant and the FIFO has room for a burst.
  assign memReq = (state_ff == ST_REQ) && displayEnable && fifoReady;
  assign memAddr = {bankAct_ff, curPtr_ff, 1'b0};
  assign fifoFlush = ~displayEnable;
  assign fifoLowerHalf = onLower_ff;

  // Fetch sequencer.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      beat_ff <= 2'h0;
    end else if (ce) begin
      if (!displayEnable) begin
        state_ff <= ST_IDLE;
        beat_ff <= 2'h0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_REQ;
          end
          ST_REQ: begin
            beat_ff <= 2'h0;
            if (memReq && memGnt) begin
              state_ff <= ST_BEAT;
            end
          end
          ST_BEAT: begin
            if (memRdValid) begin
              beat_ff <= beat_ff + 2'h1;
              if (beat_ff == `LFB_LAST_BEAT) begin
                state_ff <= ST_STEP;
              end
            end
          end
          default: begin
            state_ff <= ST_REQ;
          end
        endcase
      end
    end
  end

  // Address counters, line starts and line counter.
  always_ff @(posedge clk) begin
    if (rst) begin
      bankAct_ff <= 6'h00;
      curPtr_ff <= 21'h000000;
      startU_ff <= 21'h000000;
      startL_ff <= 21'h000000;
      onLower_ff <= 1'b0;
      rem_ff <= 10'h000;
      line_counter_ff <= 10'h000;
    end else if (ce) begin
      if ((displayEnable && state_ff == ST_IDLE) || frameDone) begin
        // Frame start takes the latest bank and base values.
        bankAct_ff <= frameStartUpper_ff[`LFB_BANK_HI:`LFB_BANK_LO];
        curPtr_ff <= frameStartUpper_ff[`LFB_BASE_HI:`LFB_BASE_LO];
        startU_ff <= frameStartUpper_ff[`LFB_BASE_HI:`LFB_BASE_LO];
        startL_ff <= frameStartLower_ff[`LFB_BASE_HI:`LFB_BASE_LO];
        onLower_ff <= 1'b0;
        rem_ff <= {1'b0, page_width_a};
        line_counter_ff <= vertLines;
      end else if (displayEnable && state_ff == ST_STEP) begin
        if (!lastBurst) begin
          curPtr_ff <= curPtr_ff + 21'h000008;
          rem_ff <= rem_ff - `LFB_BURST_HW;
        end else begin
          rem_ff <= {1'b0, page_width_a};
          if (onLower_ff) begin
            startL_ff <= newStart;
          end else begin
            startU_ff <= newStart;
          end
          if (dualScan && !onLower_ff) begin
            onLower_ff <= 1'b1;
            curPtr_ff <= startL_ff;
          end else begin
            onLower_ff <= 1'b0;
            curPtr_ff <= dualScan ? startU_ff : newStart;
            line_counter_ff <= line_counter_ff - 10'h001;
          end
        end
      end
    end
  end

  lfb_byte_order u_order (
    .din(memRdData),
    .swap(frameStartLower_ff[`LFB_SWAP_BIT]),
    .dout(swapped)
  );

  // Fetched words enter the display FIFO in the selected byte order.
  always_ff @(posedge clk) begin
    if (rst) begin
      fifoWrValid_ff <= 1'b0;
      fifoWrData_ff <= 32'h00000000;
    end else if (ce) begin
      fifoWrValid_ff <= beatTaken && displayEnable;
      if (beatTaken) begin
        fifoWrData_ff <= swapped;
      end
    end
  end
  assign fifoWrValid = fifoWrValid_ff;
  assign fifoWrData = fifoWrData_ff;

  lfb_alt_drive u_alt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .lineEnd(lineDone && (!dualScan || onLower_ff)),
    .frameEnd(frameDone),
    .toggleMode(control_ff[`LFB_TMODE_BIT]),
    .toggleRate(frameStartLower_ff[`LFB_RATE_HI:`LFB_RATE_LO]),
    .altDriveSignal(altDriveSignal)
  );

  AST_SELF_REFRESH: assert property (@(posedge clk) disable iff (rst)
    ce && regWrStb && regAddr == `LFB_OFS_TEST |=> panelSelfRefreshEn == $past(regWrData[0]))
    else $error("Self refresh bit did not follow the write.");
  AST_BANK_BITS: assert property (@(posedge clk) disable iff (rst)
    memReq |-> memAddr[27:22] == frameStartUpper_ff[`LFB_BANK_HI:`LFB_BANK_LO]
    && memAddr[0] == 1'b0)
    else $error("Fetch address lost its bank bits.");
  AST_BASE_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && displayEnable && state_ff != ST_IDLE && !frameDone |=> startU_ff != $past(startU_ff)
    |-> $past(lineDone)) else $error("Base moved inside a frame.");
  AST_FOUR_BEATS: assert property (@(posedge clk) disable iff (rst)
    ce && displayEnable && beatTaken && beat_ff == 2'h3 |=> state_ff == ST_STEP)
    else $error("Burst did not end after four beats.");
  AST_FIFO_BEAT: assert property (@(posedge clk) disable iff (rst)
    ce && displayEnable && beatTaken |=> fifoWrValid)
    else $error("Fetched beat did not reach the display FIFO.");
  AST_BURST_STEP: assert property (@(posedge clk) disable iff (rst)
    ce && displayEnable && state_ff == ST_STEP && !lastBurst
    |=> curPtr_ff == $past(curPtr_ff) + 21'h000008)
    else $error("Pointer did not advance by one burst.");
  AST_DISABLE: assert property (@(posedge clk) disable iff (rst)
    ce && !displayEnable |-> fifoFlush ##1 state_ff == ST_IDLE && !memReq)
    else $error("Disable did not stop the fetch.");
  AST_LINE_COUNT: assert property (@(posedge clk) disable iff (rst)
    frameDone |=> line_counter_ff == $past(vertLines))
    else $error("Line counter not reloaded at frame start.");
  AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (rst)
    lineDone && !frameDone && (!dualScan || onLower_ff)
    |=> line_counter_ff == $past(line_counter_ff) - 10'h001)
    else $error("Line counter did not count down.");
  AST_READ_COUNT: assert property (@(posedge clk) disable iff (rst)
    ce && regRdStb && regAddr == `LFB_OFS_CONTROL |=> regRdData[31:22] == $past(line_counter_ff))
    else $error("Line counter read did not return the count.");
  AST_FRAME_RELOAD: assert property (@(posedge clk) disable iff (rst)
    frameDone |=> curPtr_ff == $past(frameStartUpper_ff[`LFB_BASE_HI:`LFB_BASE_LO])
    && startL_ff == $past(frameStartLower_ff[`LFB_BASE_HI:`LFB_BASE_LO]) && !onLower_ff)
    else $error("Counters not reloaded at frame start.");
  AST_LOWER_START: assert property (@(posedge clk) disable iff (rst)
    lineDone && dualScan && !onLower_ff |=> onLower_ff && curPtr_ff == $past(startL_ff))
    else $error("Lower half did not start at its own counter.");
  AST_BYTE_ORDER: assert property (@(posedge clk) disable iff (rst)
    ce && beatTaken && frameStartLower_ff[`LFB_SWAP_BIT]
    |=> fifoWrData_ff[7:0] == $past(memRdData[31:24]))
    else $error("Swapped word has the wrong byte order.");
  AST_LINE_SKIP: assert property (@(posedge clk) disable iff (rst)
    lineDone && !dualScan && !frameDone |=> curPtr_ff == $past(newStart))
    else $error("Line end did not skip by the offset.");
endmodule

/* File: lfb_cfg.svh */
// Constants for the frame-buffer address generator: offsets, fields, resets, counts.
// Assumes a 32-bit register port and a word-wide burst read port to system memory.
`ifndef LFB_CFG_SVH
`define LFB_CFG_SVH
`define LFB_OFS_CONTROL 32'h01F00000
`define LFB_OFS_SIZE 32'h01F00004
`define LFB_OFS_UPPER 32'h01F00008
`define LFB_OFS_LOWER 32'h01F0000C
`define LFB_OFS_GEOM 32'h01F00010
`define LFB_OFS_TEST 32'h01F00040
`define LFB_MASK_CONTROL 32'h000000E1
`define LFB_MASK_SIZE 32'h000003FF
`define LFB_MASK_UPPER 32'h1FFFFFFF
`define LFB_MASK_LOWER 32'h3FFFFFFF
`define LFB_MASK_GEOM 32'h000FFFFF
`define LFB_MASK_TEST 32'h00000001
`define LFB_RST_REG 32'h00000000
`define LFB_ENABLE_BIT 0
`define LFB_TMODE_BIT 7
`define LFB_SCAN_HI 6
`define LFB_SCAN_LO 5
`define LFB_LCNT_HI 31
`define LFB_LCNT_LO 22
`define LFB_VLC_HI 9
`define LFB_VLC_LO 0
`define LFB_PIX_HI 28
`define LFB_PIX_LO 27
`define LFB_BANK_HI 26
`define LFB_BANK_LO 21
`define LFB_BASE_HI 20
`define LFB_BASE_LO 0
`define LFB_SWAP_BIT 29
`define LFB_RATE_HI 28
`define LFB_RATE_LO 21
`define LFB_OFF_HI 19
`define LFB_OFF_LO 9
`define LFB_PW_HI 8
`define LFB_PW_LO 0
`define LFB_SREF_BIT 0
`define LFB_LAST_BEAT 2'h3
`define LFB_BURST_HW 10'h008
`endif

/* File: lfb_pkg.sv */
// Types shared by the frame-buffer address generator files.
// Assumes the constants header is included by each design file.
package lfb_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_REQ = 2'h1,
    ST_BEAT = 2'h3,
    ST_STEP = 2'h2
  } lfb_state_t;
  typedef enum logic [1:0] {
    SCAN_DUAL4 = 2'h0,
    SCAN_SINGLE4 = 2'h1,
    SCAN_SINGLE8 = 2'h2,
    SCAN_UNUSED = 2'h3
  } lfb_scan_t;
  typedef enum logic [1:0] {
    PIX_MONO = 2'h0,
    PIX_GRAY4 = 2'h1,
    PIX_GRAY16 = 2'h2,
    PIX_COLOR = 2'h3
  } lfb_pix_t;
endpackage

/* File: lfb_byte_order.sv */
// Byte order stage: passes a fetched word straight or with its bytes reversed.
// Assumes a registered consumer; purely combinational.
`timescale 1ns/100ps
module lfb_byte_order (
  // Word in and swap select.
  input wire logic [31:0] din,
  input wire logic swap,
  // Word out.
  output logic [31:0] dout
);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      // Swapped lane gi takes the mirrored byte of the word.
      assign dout[8*gi+7:8*gi] = swap ? din[8*(3-gi)+7:8*(3-gi)] : din[8*gi+7:8*gi];
    end
  endgenerate
endmodule

/* File: lfb_alt_drive.sv */
// Alternating panel drive signal: toggles per frame or after a programmed line count.
// Assumes line and frame end pulses from the fetch logic on the same clock.
`timescale 1ns/100ps
`include "lfb_cfg.svh"
module lfb_alt_drive (
  // Clock, reset, enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Events and settings.
  input wire logic lineEnd,
  input wire logic frameEnd,
  input wire logic toggleMode,
  input wire logic [7:0] toggleRate,
  // Drive signal.
  output logic altDriveSignal
);
  logic [7:0] line_counter_ff;
  logic altSig_ff;
  assign altDriveSignal = altSig_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      line_counter_ff <= 8'h00;
      altSig_ff <= 1'b0;
    end else if (ce) begin
      if (!toggleMode) begin
        line_counter_ff <= 8'h00;
        if (frameEnd) begin
          altSig_ff <= ~altSig_ff;
        end
      end else if (lineEnd) begin
        // Toggle once one line more than the programmed number has passed.
        if (line_counter_ff >= toggleRate) begin
          line_counter_ff <= 8'h00;
          altSig_ff <= ~altSig_ff;
        end else begin
          line_counter_ff <= line_counter_ff + 8'h01;
        end
      end
    end
  end

  AST_ALT_RATE_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && toggleMode && lineEnd && (line_counter_ff < toggleRate) |=> altSig_ff == $past(altSig_ff))
    else $error("Drive signal toggled early.");
  AST_ALT_FRAME: assert property (@(posedge clk) disable iff (rst)
    ce && !toggleMode && frameEnd |=> altSig_ff != $past(altSig_ff))
    else $error("Drive signal missed its frame toggle.");
endmodule

/* File: lfb_mem_model.sv */
// Partner model: system memory answering each granted request with four read beats.
// Assumes the generator's request/grant port on one clock; slow puts a gap between beats.
`timescale 1ns/100ps
module lfb_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Pacing.
  input wire logic slow,
  // Burst read port.
  input wire logic memReq,
  input wire logic [27:0] memAddr,
  output logic memGnt,
  output logic memRdValid,
  output logic [31:0] memRdData
);
  logic [27:0] addr_ff;
  logic [1:0] beat_ff;
  logic busy_ff;
  always @(posedge clk) begin
    if (rst) begin
      memGnt <= 1'b0;
      memRdValid <= 1'b0;
      memRdData <= 32'h0;
      busy_ff <= 1'b0;
      beat_ff <= 2'h0;
      addr_ff <= 28'h0;
    end else begin
      memGnt <= memReq && !memGnt && !busy_ff;
      memRdValid <= 1'b0;
      // Idle data lines keep changing so no stale word looks valid.
      memRdData <= ~memRdData;
      if (memReq && memGnt) begin
        busy_ff <= 1'b1;
        addr_ff <= memAddr;
        beat_ff <= 2'h0;
      end else if (busy_ff && !(slow && memRdValid)) begin
        // Four beats for every grant.
        memRdValid <= 1'b1;
        memRdData <= {addr_ff, 2'h0, beat_ff};
        beat_ff <= beat_ff + 2'h1;
        busy_ff <= (beat_ff != 2'h3);
      end
    end
  end
endmodule

/* File: tb.sv */
// Self-checking testbench for the frame-buffer address generator.
// Assumes lfb_pkg, lfb_cfg.svh and lfb_mem_model are compiled first.
`timescale 1ns/100ps
`include "lfb_cfg.svh"
module tb;
  import lfb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] regAddr = 32'h0, regWrData = 32'h0, regRdData, memRdData, fifoWrData;
  logic regWrStb = 1'b0, regRdStb = 1'b0, fifoReady = 1'b0, slowMem = 1'b0, holdOff = 1'b0;
  logic memReq, memGnt, memRdValid, fifoWrValid, fifoFlush, fifoLowerHalf, displayEnable;
  logic panelSelfRefreshEn, altDriveSignal, frameEnd, altPrev, dual, swp;
  logic [27:0] memAddr;
  lfb_pix_t pixelFormatSel;
  lfb_scan_t scanMode;
  logic [5:0] bank;
  logic [20:0] upB, loB;
  logic [8:0] pw;
  logic [10:0] off;
  logic [9:0] vlc;
  int fail_count = 0, tests_run = 0, cycles = 0, feCnt = 0, wrCnt = 0, togCnt = 0;
  logic [27:0] grantQ[$];
  logic [31:0] beatQ[$];
  logic lowQ[$];
  logic [31:0] b;
  logic [31:0] regs[5] = '{`LFB_OFS_SIZE, `LFB_OFS_UPPER, `LFB_OFS_LOWER, `LFB_OFS_GEOM,
    `LFB_OFS_TEST};
  logic [31:0] masks[5] = '{`LFB_MASK_SIZE, `LFB_MASK_UPPER, `LFB_MASK_LOWER, `LFB_MASK_GEOM,
    `LFB_MASK_TEST};

  always #10 clk = ~clk;

  lfb_addr_gen lfb_addr_gen_inst (.clk, .rst, .ce(1'b1), .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .memReq, .memAddr, .memGnt, .memRdValid, .memRdData, .fifoReady,
    .fifoWrValid, .fifoWrData, .fifoFlush, .fifoLowerHalf, .displayEnable, .panelSelfRefreshEn,
    .pixelFormatSel, .scanMode, .altDriveSignal, .frameEnd);
  lfb_mem_model lfb_mem_model_inst (.clk, .rst, .slow(slowMem), .memReq, .memAddr, .memGnt,
    .memRdValid, .memRdData);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkN(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Monitor: grants, beats, frame ends, drive toggles, FIFO words, timeout.
  always @(posedge clk) begin
    cycles++;
    if (memReq && memGnt) begin
      grantQ.push_back(memAddr);
      lowQ.push_back(fifoLowerHalf);
    end
    if (memRdValid) beatQ.push_back(memRdData);
    if (frameEnd) feCnt++;
    if (!rst && altDriveSignal !== altPrev) togCnt++;
    altPrev = altDriveSignal;
    if (fifoWrValid) begin
      wrCnt++;
      b = beatQ.pop_front();
      chk("fifo word", swp ? {b[7:0], b[15:8], b[23:16], b[31:24]} : b, fifoWrData);
    end
    if (cycles > 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  always @(posedge clk) begin
    fifoReady <= !holdOff && ($urandom % 4 != 0);
    slowMem <= $urandom % 2;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask

  function automatic logic [27:0] expAddr(input int k, input logic [20:0] ub,
    input logic [20:0] lb);
    int n, l;
    logic [20:0] p;
    n = (pw + 7) / 8;
    l = k / n;
    p = (dual && l % 2) ? lb : ub;
    p = 21'(p + (dual ? l / 2 : l) * (pw + off) + (k % n) * 8);
    return {bank, p, 1'b0};
  endfunction

  task automatic pick();
    bank = 6'($urandom);
    upB = 21'($urandom % 32'h100000);
    pw = 9'(1 + $urandom % 20);
    off = 11'($urandom % 40);
    vlc = 10'(1 + $urandom % 3);
    loB = 21'(upB + (pw + off) * (vlc + 1));
  endtask

  task automatic runFrames(input int nf, input logic chg, input logic tm, input logic [7:0] rt);
    int gpf, ng;
    logic [20:0] nu, nl;
    logic [31:0] d;
    gpf = (vlc + 1) * ((pw + 7) / 8) * (dual ? 2 : 1);
    nu = upB + 21'h100;
    nl = 21'(nu + (pw + off) * (vlc + 1));
    grantQ.delete();
    beatQ.delete();
    lowQ.delete();
    feCnt = 0;
    wrCnt = 0;
    togCnt = 0;
    // Geometry and bank are set while the display is off.
    wr(`LFB_OFS_UPPER, {3'h0, 2'h3, bank, upB});
    wr(`LFB_OFS_LOWER, {2'h0, swp, rt, loB});
    wr(`LFB_OFS_GEOM, {12'h0, off, pw});
    wr(`LFB_OFS_SIZE, {22'h0, vlc});
    // Single scan uses the 8-bit panel type when the rate-driven toggle mode is on.
    wr(`LFB_OFS_CONTROL, {24'h0, tm, !dual && tm, !dual && !tm, 4'h0, 1'b1});
    rd(`LFB_OFS_CONTROL, d);
    chk("line counter", {22'h0, vlc}, {22'h0, d[31:22]});
    chk("display enable", 32'h1, 32'(displayEnable));
    if (chg) begin
      // New bases go in early in the frame, far from its end.
      while (grantQ.size() == 0) @(posedge clk);
      wr(`LFB_OFS_UPPER, {3'h0, 2'h3, bank, nu});
      wr(`LFB_OFS_LOWER, {2'h0, swp, rt, nl});
    end
    while (feCnt < nf) @(posedge clk);
    holdOff <= 1'b1;
    repeat (16) @(posedge clk);
    wr(`LFB_OFS_CONTROL, 32'h0);
    holdOff <= 1'b0;
    ng = grantQ.size();
    repeat (20) @(posedge clk);
    chk("flush", 32'h1, 32'(fifoFlush));
    chkN("grants while off", ng, grantQ.size());
    for (int k = 0; k < nf * gpf; k++) begin
      chk("fetch address", expAddr(k % gpf, (chg && k >= gpf) ? nu : upB,
        (chg && k >= gpf) ? nl : loB), 32'(grantQ[k]));
      chk("lower half", 32'(dual && ((k % gpf) / ((pw + 7) / 8)) % 2),
        32'(lowQ[k]));
    end
    chkN("fifo words", 4 * grantQ.size(), wrCnt);
    chkN("drive toggles", tm ? nf * (vlc + 1) / (rt + 1) : nf, togCnt);
    $display("frame test done: dual %0d swap %0d mode %0d", dual, swp, tm);
  endtask

  initial begin
    logic [31:0] d, r;
    r = $urandom(32'hf507);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`LFB_OFS_CONTROL, d);
    chk("reset value", 32'h0, d);
    foreach (regs[i]) begin
      rd(regs[i], d);
      chk("reset value", 32'h0, d);
      r = $urandom;
      wr(regs[i], r);
      rd(regs[i], d);
      chk("read back", r & masks[i], d);
    end
    wr(32'h01F00044, 32'hFFFFFFFF);
    rd(32'h01F00044, d);
    chk("unmapped read", 32'h0, d);
    for (int i = 1; i >= 0; i--) begin
      wr(`LFB_OFS_TEST, 32'(i));
      chk("self refresh", 32'(i), 32'(panelSelfRefreshEn));
    end
    for (int i = 0; i < 4; i++) begin
      wr(`LFB_OFS_UPPER, {3'h0, 2'(i), 27'h0});
      chk("pixel format", 32'(i), 32'(pixelFormatSel));
      wr(`LFB_OFS_CONTROL, {25'h0, 2'(i), 5'h0});
      chk("scan mode", 32'(i), 32'(scanMode));
    end
    $display("register test done");
    pick();
    dual = 1'b0;
    swp = 1'b0;
    runFrames(2, 1'b0, 1'b0, 8'h00);
    pick();
    dual = 1'b1;
    swp = 1'b1;
    runFrames(2, 1'b1, 1'b0, 8'h00);
    pick();
    vlc = 10'h3;
    dual = 1'b0;
    swp = 1'($urandom);
    runFrames(2, 1'b0, 1'b1, 8'h01);
    report_and_stop();
  end
endmodule
